// file: tpg_pkg.sv
package tpg_pkg;
	localparam int TPG_PORTS      = 3;
	localparam int TPG_PINS       = 8;
	localparam int TPG_TOTAL_PINS = TPG_PORTS * TPG_PINS;
	localparam int TPG_MODE_W     = 4;
	localparam int TPG_HALF_PINS  = 4;
	localparam int TPG_CFG_W      = TPG_HALF_PINS * TPG_MODE_W;

	// pin mode codes, 4 bits per pin
	typedef enum logic [3:0]
	{
		TPG_MODE_ANALOG   = 4'h0,
		TPG_MODE_PP_OUT   = 4'h1,
		TPG_MODE_IN_FLOAT = 4'h4,
		TPG_MODE_OD_OUT   = 4'h5,
		TPG_MODE_IN_PULL  = 4'h8,
		TPG_MODE_ALT_PP   = 4'h9
	} tpg_mode_t;

	// reset values: all pins floating input, latch low, no wake pins
	localparam logic [TPG_CFG_W-1:0] TPG_CFG_RESET   = 16'h4444;
	localparam logic [7:0]           TPG_LATCH_RESET = 8'h00;
	localparam logic [7:0]           TPG_WAKE_RESET  = 8'h00;
	localparam logic [7:0]           TPG_ZERO8       = 8'h00;
	// the regulator control pin sits at port 0, pin 7
	localparam int TPG_REG_PORT = 0;
	localparam int TPG_REG_PIN  = 7;
endpackage

// file: tpg_pin_cell.sv
`timescale 1ns/1ps
`default_nettype none
// one pin: mode decode, output driver choice, input conditioning
module tpg_pin_cell
	import tpg_pkg::*;
(
	// configuration
	input  wire logic [3:0] mode,
	input  wire logic       latch_bit,
	input  wire logic       alt_out,
	// pin side
	input  wire logic       pad_sync,
	output logic            pad_out,
	output logic            pad_oe,
	output logic            pull_en,
	output logic            pull_up,
	// conditioned input
	output logic            level
);
	// decode the mode into driver and pull controls
	always_comb
	begin
		pad_out = 1'b0;
		pad_oe  = 1'b0;
		pull_en = 1'b0;
		pull_up = 1'b0;
		level   = pad_sync;
		case (mode)
			// R1 analog forces high input
			TPG_MODE_ANALOG: level = 1'b1;
			// R3 latch drives output
			TPG_MODE_PP_OUT:
			begin
				pad_out = latch_bit;
				pad_oe  = 1'b1;
			end
			// open drain: only drive while pulling low
			TPG_MODE_OD_OUT:
			begin
				pad_out = 1'b0;
				pad_oe  = ~latch_bit;
			end
			// R3 peripheral drives output
			TPG_MODE_ALT_PP:
			begin
				pad_out = alt_out;
				pad_oe  = 1'b1;
			end
			// R14 latch picks pull direction
			TPG_MODE_IN_PULL:
			begin
				pull_en = 1'b1;
				pull_up = latch_bit;
			end
			// R4 inputs and unknown codes stay undriven
			default: pad_oe = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

// file: tpg_core.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1 - analog pin input bit reads one
// R2 - conditioned input feeds register, peripherals, wake
// R3 - one driver: latch or peripheral
// R4 - no output drive in input, analog
// R5 - 24 pins, three ports, bit equals pin
// R6 - low eight register bits map pins
// R7 - input register shows pin levels
// R8 - clear strobe clears selected latch bits
// R9 - set strobe sets selected latch bits
// R10 - wake mask selects pins that wake
// R11 - lower config pins 3-0, upper 7-4
// R12 - regulator pin pulled low in deep sleep
// R13 - four-bit mode codes per pin
// R14 - pull pin: latch selects up or down
// R15 - zero strobe bits change nothing
module tpg_core
	import tpg_pkg::*;
(
	// clock and reset
	input  wire logic                      mclk,
	input  wire logic                      rst,
	// configuration writes, per port
	input  wire logic [TPG_PORTS-1:0]      lower_cfg_we,
	input  wire logic [TPG_PORTS-1:0]      upper_cfg_we,
	input  wire logic [TPG_PORTS-1:0]      latch_we,
	input  wire logic [TPG_PORTS-1:0]      wake_we,
	input  wire logic [TPG_CFG_W-1:0]      cfg_wdata,
	input  wire logic [7:0]                byte_wdata,
	// output strobes: one-cycle, data is byte_wdata
	input  wire logic [TPG_PORTS-1:0]      output_set_strobe,
	input  wire logic [TPG_PORTS-1:0]      output_clear_strobe,
	// register views
	output logic [TPG_TOTAL_PINS-1:0]      pin_level_input,
	output logic [TPG_TOTAL_PINS-1:0]      output_latch,
	output logic [TPG_TOTAL_PINS-1:0]      wake_pin_mask,
	output logic [TPG_PORTS*TPG_CFG_W-1:0] lower_pin_config,
	output logic [TPG_PORTS*TPG_CFG_W-1:0] upper_pin_config,
	// peripherals
	input  wire logic [TPG_TOTAL_PINS-1:0] alt_out,
	output logic [TPG_TOTAL_PINS-1:0]      alt_in,
	// wake and interrupt
	output logic [TPG_TOTAL_PINS-1:0]      wake_level,
	output logic                           wake_event,
	output logic [TPG_TOTAL_PINS-1:0]      irq_level,
	// regulator control
	input  wire logic                      ext_reg_enable,
	input  wire logic                      deep_sleep,
	// pads
	input  wire logic [TPG_TOTAL_PINS-1:0] pad_in,
	output logic [TPG_TOTAL_PINS-1:0]      pad_out,
	output logic [TPG_TOTAL_PINS-1:0]      pad_oe,
	output logic [TPG_TOTAL_PINS-1:0]      pad_pull_en,
	output logic [TPG_TOTAL_PINS-1:0]      pad_pull_up,
	output logic                           regulator_control_pin_out,
	output logic                           regulator_control_pin_oe
);
	logic [TPG_TOTAL_PINS-1:0] sync1;
	logic [TPG_TOTAL_PINS-1:0] sync2;
	logic [TPG_TOTAL_PINS-1:0] level;
	logic [TPG_TOTAL_PINS-1:0] prev_level;
	logic [TPG_TOTAL_PINS-1:0] next_latch;
	logic [TPG_TOTAL_PINS-1:0] next_wake;
	logic [TPG_TOTAL_PINS-1:0] next_in;
	logic [TPG_PORTS*TPG_CFG_W-1:0] next_lower;
	logic [TPG_PORTS*TPG_CFG_W-1:0] next_upper;
	logic [TPG_TOTAL_PINS-1:0] cell_out;
	logic [TPG_TOTAL_PINS-1:0] cell_oe;
	logic                      next_wake_event;

	// pick one pin's mode out of the two config words
	function automatic logic [3:0] pin_mode(input logic [TPG_CFG_W-1:0] lo,
		input logic [TPG_CFG_W-1:0] hi, input int pin);
		logic [3:0] m;
		// R11 lower word pins 3-0
		if (pin < TPG_HALF_PINS)
			m = lo[pin*TPG_MODE_W +: TPG_MODE_W];
		else
			m = hi[(pin-TPG_HALF_PINS)*TPG_MODE_W +: TPG_MODE_W];
		return m;
	endfunction

	// R5 per-pin cells, bit index equals pin
	genvar gp;
	genvar gb;
	generate
		for (gp = 0; gp < TPG_PORTS; gp++)
		begin : g_port
			for (gb = 0; gb < TPG_PINS; gb++)
			begin : g_pin
				logic [3:0] cell_mode;
				// R13 mode decoded per pin
				assign cell_mode = pin_mode(lower_pin_config[gp*TPG_CFG_W +: TPG_CFG_W],
					upper_pin_config[gp*TPG_CFG_W +: TPG_CFG_W], gb);
				tpg_pin_cell u_cell (
					.mode      (cell_mode),
					.latch_bit (output_latch[gp*TPG_PINS+gb]),
					.alt_out   (alt_out[gp*TPG_PINS+gb]),
					.pad_sync  (sync2[gp*TPG_PINS+gb]),
					.pad_out   (cell_out[gp*TPG_PINS+gb]),
					.pad_oe    (cell_oe[gp*TPG_PINS+gb]),
					.pull_en   (pad_pull_en[gp*TPG_PINS+gb]),
					.pull_up   (pad_pull_up[gp*TPG_PINS+gb]),
					.level     (level[gp*TPG_PINS+gb])
				);
				// R4 no drive in input or analog
				in_no_drive_a: assert property (@(posedge mclk) disable iff (rst) // R4
					(cell_mode == TPG_MODE_IN_FLOAT || cell_mode == TPG_MODE_ANALOG
					|| cell_mode == TPG_MODE_IN_PULL) |-> !cell_oe[gp*TPG_PINS+gb])
					else $error("driver on in input mode");
			end
		end
	endgenerate

	// the regulator pin keeps its normal cell on the ordinary pad outputs
	assign pad_out = cell_out;
	assign pad_oe  = cell_oe;

	// R12 open drain low only in deep sleep
	assign regulator_control_pin_out = 1'b0;
	assign regulator_control_pin_oe  = ext_reg_enable & deep_sleep;

	// R2 conditioned input fanned out
	assign alt_in    = level;
	assign irq_level = level;
	assign wake_level = level & wake_pin_mask;

	// register next values
	always_comb
	begin
		next_latch = output_latch;
		next_wake  = wake_pin_mask;
		next_lower = lower_pin_config;
		next_upper = upper_pin_config;
		// R7 input register samples conditioned level
		next_in = level;
		// R10 pins that changed and are enabled wake
		next_wake_event = |((level ^ prev_level) & wake_pin_mask);
		// R6 byte lanes map pins
		for (int p = 0; p < TPG_PORTS; p++)
		begin
			if (lower_cfg_we[p])
				next_lower[p*TPG_CFG_W +: TPG_CFG_W] = cfg_wdata;
			if (upper_cfg_we[p])
				next_upper[p*TPG_CFG_W +: TPG_CFG_W] = cfg_wdata;
			if (wake_we[p])
				next_wake[p*TPG_PINS +: TPG_PINS] = byte_wdata;
			if (latch_we[p])
				next_latch[p*TPG_PINS +: TPG_PINS] = byte_wdata;
			// R15 zero bits keep latch
			// R8 clear selected bits
			if (output_clear_strobe[p])
				next_latch[p*TPG_PINS +: TPG_PINS] =
					next_latch[p*TPG_PINS +: TPG_PINS] & ~byte_wdata;
			// R9 set selected bits, set wins
			if (output_set_strobe[p])
				next_latch[p*TPG_PINS +: TPG_PINS] =
					next_latch[p*TPG_PINS +: TPG_PINS] | byte_wdata;
		end
	end

	// state registers
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			sync1            <= '0;
			sync2            <= '0;
			prev_level       <= '0;
			pin_level_input  <= '0;
			output_latch     <= {TPG_PORTS{TPG_LATCH_RESET}};
			wake_pin_mask    <= {TPG_PORTS{TPG_WAKE_RESET}};
			lower_pin_config <= {TPG_PORTS{TPG_CFG_RESET}};
			upper_pin_config <= {TPG_PORTS{TPG_CFG_RESET}};
			wake_event       <= 1'b0;
		end
		else
		begin
			// pads are asynchronous: two stages before use
			sync1            <= pad_in;
			sync2            <= sync1;
			prev_level       <= level;
			pin_level_input  <= next_in;
			output_latch     <= next_latch;
			wake_pin_mask    <= next_wake;
			lower_pin_config <= next_lower;
			upper_pin_config <= next_upper;
			wake_event       <= next_wake_event;
		end
	end

	// R15 zero strobe bits keep latch
	strobe_keep_a: assert property (@(posedge mclk) disable iff (rst) // R15
		(output_set_strobe[0] && !latch_we[0] && !output_clear_strobe[0])
		|=> ((output_latch[7:0] & ~$past(byte_wdata)) == ($past(output_latch[7:0])
		& ~$past(byte_wdata)))) else $error("zero set bits changed latch");
	// R9 set bits land
	set_bits_a: assert property (@(posedge mclk) disable iff (rst) // R9
		output_set_strobe[1] |=> ((output_latch[15:8] & $past(byte_wdata)) == $past(byte_wdata)))
		else $error("set strobe failed");
	// R8 clear bits land
	clear_bits_a: assert property (@(posedge mclk) disable iff (rst) // R8
		(output_clear_strobe[2] && !output_set_strobe[2])
		|=> ((output_latch[23:16] & $past(byte_wdata)) == TPG_ZERO8))
		else $error("clear strobe failed");
	// R12 regulator pin follows sleep, only ever pulls low
	reg_pin_a: assert property (@(posedge mclk) disable iff (rst) // R12
		(regulator_control_pin_oe == (ext_reg_enable && deep_sleep)) && !regulator_control_pin_out)
		else $error("regulator pin wrong");
	// R1 analog pin reads one, port 2 pin 0
	analog_high_a: assert property (@(posedge mclk) disable iff (rst) // R1
		(lower_pin_config[35:32] == TPG_MODE_ANALOG) |=> pin_level_input[16])
		else $error("analog pin not one");
	// R7 input follows synced pad
	input_follow_a: assert property (@(posedge mclk) disable iff (rst) // R7
		(lower_pin_config[7:4] == TPG_MODE_IN_FLOAT) |=> pin_level_input[1] == $past(sync2[1]))
		else $error("input register wrong");
	// R10 masked pins never wake
	wake_mask_a: assert property (@(posedge mclk) disable iff (rst) // R10
		(wake_pin_mask == '0) |=> !wake_event) else $error("masked wake");
	// R3 alternate mode drives peripheral value, port 1 pin 7
	alt_drive_a: assert property (@(posedge mclk) disable iff (rst) // R3
		(upper_pin_config[31:28] == TPG_MODE_ALT_PP) |-> (pad_oe[15] && pad_out[15] == alt_out[15]))
		else $error("alternate driver wrong");
endmodule
`default_nettype wire

// file: tpg_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
// far side: board pads and the peripherals behind the alternate outputs
module tpg_pad_model
	import tpg_pkg::*;
(
	// clock
	input  wire logic                      mclk,
	// pad drive from the core
	input  wire logic [TPG_TOTAL_PINS-1:0] pad_out,
	input  wire logic [TPG_TOTAL_PINS-1:0] pad_oe,
	input  wire logic [TPG_TOTAL_PINS-1:0] pull_en,
	input  wire logic [TPG_TOTAL_PINS-1:0] pull_up,
	// board sources on undriven pins
	input  wire logic [TPG_TOTAL_PINS-1:0] ext_drive,
	// back to the core
	output logic [TPG_TOTAL_PINS-1:0]      pad_in,
	output logic [TPG_TOTAL_PINS-1:0]      alt_out
);
	// wire level: core driver first, then pull, then board source
	always_comb
		for (int i = 0; i < TPG_TOTAL_PINS; i++)
			pad_in[i] = pad_oe[i] ? pad_out[i] : (pull_en[i] ? pull_up[i] : ext_drive[i]);
	// peripheral pattern moves every cycle so a stale route cannot match;
	// it moves 3 ns after the rising edge, away from the bench's drive and sample instants
	initial alt_out = 24'h5A3C96;
	always @(posedge mclk)
		alt_out <= #3 {alt_out[22:0], ~alt_out[23]};
endmodule
`default_nettype wire

// file: three_port_gpio_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
	$display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module three_port_gpio_core_tb;
	import tpg_pkg::*;
	typedef struct {int s; logic [23:0] m; logic [23:0] v;} tpg_note_t;
	logic mclk = 1'b0, rst = 1'b1, ext_reg_enable = 1'b0, deep_sleep = 1'b0;
	logic [2:0] lw = '0, uw = '0, tw = '0, ww = '0, ss = '0, cs = '0;
	logic [15:0] cfg_wdata = 16'h0000;
	logic [7:0] byte_wdata = 8'h00;
	logic [23:0] ext_drive = 24'h000000, l, m, r;
	logic [23:0] pad_in, alt_out, pli, lat, msk, ain, pout, poe, pen, pup;
	logic [47:0] lcfg, ucfg;
	logic wake_event, rc_out, rc_oe;
	int n_mismatch = 0, checks_done = 0, cnt;
	tpg_note_t q[$], n;
	always #5 mclk = ~mclk;
	tpg_core u_dut (.mclk, .rst, .lower_cfg_we(lw), .upper_cfg_we(uw),
		.latch_we(tw), .wake_we(ww), .cfg_wdata, .byte_wdata, .output_set_strobe(ss),
		.output_clear_strobe(cs), .pin_level_input(pli), .output_latch(lat),
		.wake_pin_mask(msk), .lower_pin_config(lcfg), .upper_pin_config(ucfg), .alt_out,
		.alt_in(ain), .wake_level(), .wake_event, .irq_level(), .ext_reg_enable, .deep_sleep,
		.pad_in, .pad_out(pout), .pad_oe(poe), .pad_pull_en(pen), .pad_pull_up(pup),
		.regulator_control_pin_out(rc_out), .regulator_control_pin_oe(rc_oe));
	tpg_pad_model u_pads (.mclk, .pad_out(pout), .pad_oe(poe), .pull_en(pen),
		.pull_up(pup), .ext_drive, .pad_in, .alt_out);
	function automatic logic [23:0] pick(input int s);
		case (s)
			0: pick = pli;
			1: pick = lat;
			2: pick = msk;
			3: pick = pout;
			4: pick = poe;
			5: pick = pup;
			6: pick = ain;
			7: pick = lcfg[23:0];
			default: pick = ucfg[47:24];
		endcase
	endfunction
	// watcher: oldest note against the settled outputs
	always @(negedge mclk)
		if (q.size() > 0)
		begin
			n = q.pop_front();
			`CHK(pick(n.s) & n.m, n.v & n.m)
		end
	task automatic step(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask
	task automatic ex(input int s, input logic [23:0] mk, input logic [23:0] v);
		q.push_back('{s, mk, v});
	endtask
	task automatic wr(input int k, input int p, input logic [15:0] d);
		logic [17:0] sel;
		// one assignment per edge: the last strobe drops as this one rises
		sel = '0;
		if (k < 6)
			sel[(5 - k) * 3 + p] = 1'b1;
		else
			sel = 18'(9'h009 << p);
		{lw, uw, tw, ww, ss, cs} = sel;
		cfg_wdata = d;
		byte_wdata = d[7:0];
		step(1);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// drain notes under a bound, a stuck queue ends the run
	task automatic done(input string t);
		// a held strobe only repeats an idempotent write; drop it here
		{lw, uw, tw, ww, ss, cs} = '0;
		step(1);
		for (int i = 0; i < 40 && q.size() > 0; i++)
			step(1);
		if (q.size() > 0)
		begin
			n_mismatch++;
			wrap_up();
		end
		else
			$display("test %s done", t);
	endtask
	initial
	begin
		l = 24'($urandom(32'h8d874f51));
		step(3);
		rst = 1'b0;
		step(1);
		ex(1, 24'hFFFFFF, 24'h000000);
		ex(4, 24'hFFFFFF, 24'h000000);
		ex(7, 24'hFFFFFF, 24'h444444);
		ex(8, 24'hFFFFFF, 24'h444444);
		done("reset");
		// wake: masked pin then unmasked pin
		wr(3, 2, 16'h0001);
		ex(2, 24'hFFFFFF, 24'h010000);
		for (int k = 17; k >= 16; k--)
		begin
			ext_drive[k] = 1'b1;
			cnt = 0;
			repeat (8)
			begin
				step(1);
				cnt += (wake_event !== 1'b0);
			end
			`CHK(cnt, 17 - k)
		end
		done("wake");
		l = 24'($urandom);
		m = 24'($urandom);
		wr(0, 0, 16'h1111);
		wr(1, 0, 16'h5555);
		wr(2, 0, {8'h00, l[7:0]});
		wr(6, 0, {8'h00, m[7:0]});
		ex(1, 24'h0000FF, l | m);
		wr(5, 0, {8'h00, l[15:8]});
		ex(1, 24'h0000FF, (l | m) & ~l[15:8]);
		wr(4, 0, 16'h0000);
		wr(5, 0, 16'h0000);
		r = (l | m) & ~l[15:8];
		ex(1, 24'h0000FF, r);
		ex(3, 24'h00000F, r);
		ex(4, 24'h0000FF, {~r[7:4], 4'hF});
		// board pull-ups on the open-drain pins so a released pin reads high
		ext_drive[7:4] = 4'hF;
		step(4);
		ex(0, 24'h0000FF, {r[7:4] & ext_drive[7:4], r[3:0]});
		done("outputs");
		wr(0, 1, 16'h9999);
		wr(1, 1, 16'h9999);
		ex(4, 24'h00FF00, 24'h00FF00);
		step(1);
		`CHK(pout[15:8], alt_out[15:8])
		done("alternate");
		r = 24'($urandom);
		ext_drive = 24'($urandom);
		wr(2, 2, {8'h00, r[7:0]});
		wr(0, 2, 16'h0000);
		wr(1, 2, 16'h8888);
		step(4);
		ex(0, 24'hFF0000, {r[7:4], 4'hF, 16'h0000});
		ex(6, 24'hFF0000, {r[7:4], 4'hF, 16'h0000});
		ex(4, 24'hFF0000, 24'h000000);
		ex(5, 24'hF00000, {r[7:4], 20'h00000});
		done("analog_pull");
		// strobes on the other ports: set on port 1, clear all of port 2
		wr(4, 1, {8'h00, l[23:16]});
		wr(5, 2, 16'h00FF);
		ex(1, 24'h00FF00, {l[23:16], 8'h00});
		ex(1, 24'hFF0000, 24'h000000);
		for (int c = 0; c < 4; c++)
		begin
			{ext_reg_enable, deep_sleep} = c[1:0];
			step(1);
			`CHK({rc_oe, rc_out}, {c == 3, 1'b0})
		end
		done("regulator");
		wrap_up();
	end
endmodule
`default_nettype wire
